// ### rtl/brad_register_access.sv
`timescale 1ns/1ps
`default_nettype none
`include "brad_cfg.svh"

// Behaviour
// - Test input high disables every output but the result pin; board ties it low otherwise.
// - Result pin shows NAND tree in test, speaker tone otherwise in redirect variant.
// - Reserved configuration bytes complete normally, read zero, ignore writes.
// - Hard reset pin loads every register with its default.
// - Configuration registers only via configuration cycles, offset AD[7:2], lanes C/BE#.
// - Configuration accepts byte, word, dword accesses, little-endian.
// - Legacy registers reachable from PCI, a subset from ISA.
// - Legacy multi-byte PCI access, except BIOS timer, ends in target-abort.
// - BIOS timer accepts byte, word or dword accesses.
// - Legacy accesses stay internal except 70h,60h,92h,3F2h,372h,F0h also forwarded.
// - PCI access retried while ISA master or DMA owns ISA bus.
// - BIOS timer accesses forwarded only while the timer is disabled.
// - Select and window registers, 32-bit, relocatable, 128-bit aligned in memory.
// - Select at FEC0_xy00, window at FEC0_xy10, x,y from relocation fields.
// - Select bits 7:0 pick index; window is 32-bit access to it.
// - Each entry uses even index for bits 31:0, odd for 63:32.
// - Index 00h ID rw, 01h version ro, 02h arbitration ro, 10h-2Fh entries.
module brad_register_access
  import brad_pkg::*;
#(
  parameter int TREE_W = 8,
  parameter bit HAS_REDIRECT = 1'b1,
  parameter logic [31:0] UNIT_VERSION = 32'h0000_0000, // Arbitrary value
  parameter logic [31:0] UNIT_ARB_ID = 32'h0000_0000 // Arbitrary value
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Pins
  input wire logic hard_reset_in_n_i,
  input wire logic test_i,
  input wire logic [TREE_W-1:0] nand_tree_pins_i,
  input wire logic speaker_tone_i,
  output logic outputs_enable_o,
  output logic tone_or_tree_result_out_o,
  // Access requests and answers
  input wire brad_req_type req_i,
  output logic req_ready_o,
  input wire logic isa_owned_i,
  output brad_resp_type resp_o,
  // Other register slices
  output brad_req_type ext_req_o,
  input wire logic [31:0] ext_rdata_i
);

  localparam int SW = TREE_W + 2;
  localparam int EAW = $clog2(`BRAD_ENTRY_WORDS);
  localparam logic [7:0] WIN_LOW = `BRAD_WIN_LOW;

  // More than one byte lane enabled
  function automatic logic multi_lane(input logic [3:0] be_n);
    logic [2:0] n;
    n = 3'(!be_n[0]) + 3'(!be_n[1]) + 3'(!be_n[2]) + 3'(!be_n[3]);
    return n > 3'd1;
  endfunction

  // Lowest enabled byte lane
  function automatic logic [1:0] first_lane(input logic [3:0] be_n);
    logic [1:0] l;
    l = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (!be_n[i]) begin
        l = 2'(i);
      end
    end
    return l;
  endfunction

  // Reserved configuration byte
  function automatic logic cfg_reserved(input logic [7:0] o);
    logic r;
    r = (o >= `BRAD_CFG_RSV0_LO && o <= `BRAD_CFG_RSV0_HI) ||
        (o >= `BRAD_CFG_RSV1_LO && o <= `BRAD_CFG_RSV1_HI) ||
        (o >= `BRAD_CFG_RSV2_LO && o <= `BRAD_CFG_RSV2_HI) ||
        (o >= `BRAD_CFG_RSV3_LO && o <= `BRAD_CFG_RSV3_HI) ||
        (o >= `BRAD_CFG_RSV4_LO && o <= `BRAD_CFG_RSV4_HI) ||
        (o >= `BRAD_CFG_RSV5_LO && o <= `BRAD_CFG_RSV5_HI) ||
        o == `BRAD_CFG_RSV6_OFS || o == `BRAD_CFG_RSV7_OFS ||
        o == `BRAD_CFG_RSV8_OFS || o >= `BRAD_CFG_RSV9_LO;
    if (HAS_REDIRECT) begin
      r = r || o == `BRAD_CFG_SG_OFS;
    end else begin
      r = r || o == `BRAD_CFG_PICCTL_OFS || o == `BRAD_CFG_RELOC_OFS;
    end
    return r;
  endfunction

  // Configuration byte held in this block
  function automatic logic cfg_own(input logic [7:0] o);
    return (HAS_REDIRECT && o == `BRAD_CFG_RELOC_OFS) ||
           o == `BRAD_CFG_BTMR_LO_OFS || o == `BRAD_CFG_BTMR_HI_OFS;
  endfunction

  // Legacy locations also broadcast to ISA
  function automatic logic io_forwarded(input logic [15:0] a);
    return a == `BRAD_FWD_A || a == `BRAD_FWD_B || a == `BRAD_FWD_C ||
           a == `BRAD_FWD_D || a == `BRAD_FWD_E || a == `BRAD_FWD_F;
  endfunction

  logic [SW-1:0] sync_a;
  logic [SW-1:0] sync_b;
  logic hard_rst;
  logic test_mode;
  logic [TREE_W-1:0] chain;
  logic [7:0] reloc;
  logic [15:0] btmr_base;
  logic [7:0] sel_idx;
  logic [31:0] unit_id;
  logic sweeping;
  logic [EAW-1:0] sweep_cnt;
  brad_state_type state;
  logic take;
  logic wr_ok;
  brad_kind_type kind;
  logic retry;
  logic abort;
  logic forward;
  logic [3:0] ext_be_n;
  logic [31:0] win_base;
  logic btmr_hit;
  logic idx_entry;
  brad_kind_type h_kind;
  logic h_retry;
  logic h_abort;
  logic h_forward;
  logic [3:0] h_be_n;
  logic [7:0] h_dw;
  logic [7:0] h_idx;
  logic [31:0] mem_rdata;
  logic mem_we;
  logic [EAW-1:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic [EAW-1:0] mem_raddr;
  logic [31:0] next_rdata;

  // Two-flop synchronisers for pins
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {hard_reset_in_n_i, test_i, nand_tree_pins_i};
      sync_b <= sync_a;
    end
  end

  assign hard_rst = ~sync_b[SW-1];
  assign test_mode = sync_b[SW-2];

  // NAND tree chain over the input pins
  assign chain[0] = sync_b[0];
  for (genvar i = 1; i < TREE_W; i++) begin : g_tree
    assign chain[i] = ~(chain[i-1] & sync_b[i]);
  end

  // Shared result/tone pin and global output enable
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      tone_or_tree_result_out_o <= 1'b0;
    end else if (test_mode) begin
      tone_or_tree_result_out_o <= chain[TREE_W-1];
    end else begin
      tone_or_tree_result_out_o <= HAS_REDIRECT ? speaker_tone_i : 1'b0;
    end
  end

  assign outputs_enable_o = ~test_mode;

  // Window pair location from relocation fields
  assign win_base = {`BRAD_WIN_TOP, reloc[`BRAD_RELOC_X_MSB:`BRAD_RELOC_X_LSB],
                     reloc[`BRAD_RELOC_Y_MSB:`BRAD_RELOC_Y_LSB], 2'b00, 8'h00};
  assign btmr_hit = req_i.addr[15:2] == btmr_base[15:2];
  assign idx_entry = sel_idx >= `BRAD_IDX_RED_FIRST && sel_idx <= `BRAD_IDX_RED_LAST;

  // Decode of the offered request
  always_comb begin
    kind = BRAD_K_NONE;
    abort = 1'b0;
    forward = 1'b0;
    ext_be_n = req_i.be_n;
    case (req_i.space)
      BRAD_SP_CFG: begin
        kind = BRAD_K_CFG;
        for (int i = 0; i < 4; i++) begin
          if (cfg_reserved({req_i.addr[7:2], 2'(i)}) || cfg_own({req_i.addr[7:2], 2'(i)})) begin
            ext_be_n[i] = 1'b1;
          end
        end
      end
      BRAD_SP_IO: begin
        kind = BRAD_K_LEGACY;
        if (btmr_hit) begin
          forward = ~btmr_base[`BRAD_BTMR_EN_BIT];
        end else begin
          abort = multi_lane(req_i.be_n);
          forward = ~abort & io_forwarded({req_i.addr[15:2], first_lane(req_i.be_n)});
        end
      end
      BRAD_SP_ISA_IO: begin
        kind = BRAD_K_LEGACY;
      end
      BRAD_SP_MEM: begin
        if (HAS_REDIRECT && req_i.addr[31:2] == win_base[31:2]) begin
          kind = BRAD_K_SEL;
        end else if (HAS_REDIRECT && req_i.addr[31:8] == win_base[31:8] && req_i.addr[7:2] == WIN_LOW[7:2]) begin
          kind = BRAD_K_WIN;
        end
      end
      default: begin
        kind = BRAD_K_NONE;
      end
    endcase
    retry = isa_owned_i && kind != BRAD_K_NONE && req_i.space != BRAD_SP_ISA_IO;
    if (retry) begin
      abort = 1'b0;
      forward = 1'b0;
    end
  end

  assign req_ready_o = state == BRAD_IDLE && !hard_rst && !sweeping;
  assign take = req_i.valid & req_ready_o;
  assign wr_ok = take & req_i.write & ~retry & ~abort;

  // Access sequencing
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= BRAD_IDLE;
    end else if (hard_rst) begin
      state <= BRAD_IDLE;
    end else begin
      case (state)
        BRAD_IDLE: begin
          if (take) begin
            state <= BRAD_ANSWER;
          end
        end
        BRAD_ANSWER: begin
          state <= BRAD_IDLE;
        end
        default: begin
          state <= BRAD_IDLE;
        end
      endcase
    end
  end

  // Request details held for the answer cycle
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      h_kind <= BRAD_K_NONE;
      h_retry <= 1'b0;
      h_abort <= 1'b0;
      h_forward <= 1'b0;
      h_be_n <= 4'hF;
      h_dw <= 8'h00;
      h_idx <= 8'h00;
    end else if (take) begin
      h_kind <= kind;
      h_retry <= retry;
      h_abort <= abort;
      h_forward <= forward;
      h_be_n <= req_i.be_n;
      h_dw <= {req_i.addr[7:2], 2'b00};
      h_idx <= sel_idx;
    end
  end

  // Strobe towards the other register slices
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ext_req_o <= '0;
    end else begin
      ext_req_o <= req_i;
      ext_req_o.valid <= take && !retry && !abort && (kind == BRAD_K_CFG || kind == BRAD_K_LEGACY);
      ext_req_o.be_n <= ext_be_n;
    end
  end

  // Configuration bytes held here, byte lanes little-endian
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      reloc <= `BRAD_RELOC_RST;
      btmr_base <= `BRAD_BTMR_RST;
    end else if (hard_rst) begin
      reloc <= `BRAD_RELOC_RST;
      btmr_base <= `BRAD_BTMR_RST;
    end else if (wr_ok && kind == BRAD_K_CFG) begin
      for (int i = 0; i < 4; i++) begin
        if (!req_i.be_n[i]) begin
          if (HAS_REDIRECT && {req_i.addr[7:2], 2'(i)} == `BRAD_CFG_RELOC_OFS) begin
            reloc <= req_i.wdata[8*i +: 8];
          end
          if ({req_i.addr[7:2], 2'(i)} == `BRAD_CFG_BTMR_LO_OFS) begin
            btmr_base[7:0] <= req_i.wdata[8*i +: 8];
          end
          if ({req_i.addr[7:2], 2'(i)} == `BRAD_CFG_BTMR_HI_OFS) begin
            btmr_base[15:8] <= req_i.wdata[8*i +: 8];
          end
        end
      end
    end
  end

  // Select register and unit identifier
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_idx <= `BRAD_SEL_RST;
      unit_id <= `BRAD_ID_RST;
    end else if (hard_rst) begin
      sel_idx <= `BRAD_SEL_RST;
      unit_id <= `BRAD_ID_RST;
    end else if (wr_ok && kind == BRAD_K_SEL && !req_i.be_n[0]) begin
      sel_idx <= req_i.wdata[7:0];
    end else if (wr_ok && kind == BRAD_K_WIN && sel_idx == `BRAD_IDX_ID) begin
      unit_id <= req_i.wdata;
    end
  end

  // Entry clearing sweep after hard reset
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sweeping <= 1'b0;
      sweep_cnt <= '0;
    end else if (hard_rst) begin
      sweeping <= 1'b1;
      sweep_cnt <= '0;
    end else if (sweeping) begin
      sweep_cnt <= sweep_cnt + 1'b1;
      sweeping <= sweep_cnt != EAW'(`BRAD_ENTRY_WORDS - 1);
    end
  end

  // Entry storage port control, even index low half, odd index high half
  always_comb begin
    mem_raddr = EAW'(sel_idx - `BRAD_IDX_RED_FIRST);
    mem_we = sweeping || (wr_ok && kind == BRAD_K_WIN && idx_entry);
    mem_waddr = sweeping ? sweep_cnt : mem_raddr;
    mem_wdata = sweeping ? `BRAD_ENTRY_RST : req_i.wdata;
  end

  brad_entry_mem #(
    .AW(EAW),
    .DW(32)
  ) u_entries (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .wr_en_i(mem_we),
    .wr_addr_i(mem_waddr),
    .wr_data_i(mem_wdata),
    .rd_addr_i(mem_raddr),
    .rd_data_o(mem_rdata)
  );

  // Read data for the answer cycle
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (h_kind)
      BRAD_K_CFG: begin
        for (int i = 0; i < 4; i++) begin
          if (!h_be_n[i]) begin
            if (cfg_reserved(h_dw | 8'(i))) begin
              next_rdata[8*i +: 8] = 8'h00;
            end else if ((h_dw | 8'(i)) == `BRAD_CFG_BTMR_LO_OFS) begin
              next_rdata[8*i +: 8] = btmr_base[7:0];
            end else if ((h_dw | 8'(i)) == `BRAD_CFG_BTMR_HI_OFS) begin
              next_rdata[8*i +: 8] = btmr_base[15:8];
            end else if (!cfg_own(h_dw | 8'(i))) begin
              next_rdata[8*i +: 8] = ext_rdata_i[8*i +: 8];
            end
          end
        end
      end
      BRAD_K_LEGACY: begin
        next_rdata = ext_rdata_i;
      end
      BRAD_K_SEL: begin
        next_rdata = {24'h00_0000, sel_idx};
      end
      BRAD_K_WIN: begin
        if (h_idx == `BRAD_IDX_ID) begin
          next_rdata = unit_id;
        end else if (h_idx == `BRAD_IDX_VER) begin
          next_rdata = UNIT_VERSION;
        end else if (h_idx == `BRAD_IDX_ARB) begin
          next_rdata = UNIT_ARB_ID;
        end else if (h_idx >= `BRAD_IDX_RED_FIRST && h_idx <= `BRAD_IDX_RED_LAST) begin
          next_rdata = mem_rdata;
        end
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
    if (h_retry || h_abort) begin
      next_rdata = 32'h0000_0000;
    end
  end

  // Registered one-cycle answer
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      resp_o <= '0;
    end else begin
      resp_o.done <= state == BRAD_ANSWER;
      resp_o.hit <= state == BRAD_ANSWER && h_kind != BRAD_K_NONE;
      resp_o.retry <= state == BRAD_ANSWER && h_retry;
      resp_o.target_abort <= state == BRAD_ANSWER && h_abort;
      resp_o.forward_isa <= state == BRAD_ANSWER && h_forward;
      resp_o.rdata <= state == BRAD_ANSWER ? next_rdata : 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// ### rtl/brad_cfg.svh
`ifndef BRAD_CFG_SVH
`define BRAD_CFG_SVH

// Configuration space byte offsets held in this block
`define BRAD_CFG_RELOC_OFS 8'h71
`define BRAD_CFG_BTMR_LO_OFS 8'h80
`define BRAD_CFG_BTMR_HI_OFS 8'h81

// Reserved configuration ranges, inclusive
`define BRAD_CFG_RSV0_LO 8'h09
`define BRAD_CFG_RSV0_HI 8'h3F
`define BRAD_CFG_RSV1_LO 8'h50
`define BRAD_CFG_RSV1_HI 8'h53
`define BRAD_CFG_SG_OFS 8'h57
`define BRAD_CFG_RSV2_LO 8'h58
`define BRAD_CFG_RSV2_HI 8'h5F
`define BRAD_CFG_RSV3_LO 8'h64
`define BRAD_CFG_RSV3_HI 8'h6F
`define BRAD_CFG_PICCTL_OFS 8'h70
`define BRAD_CFG_RSV4_LO 8'h72
`define BRAD_CFG_RSV4_HI 8'h7F
`define BRAD_CFG_RSV5_LO 8'h82
`define BRAD_CFG_RSV5_HI 8'h9F
`define BRAD_CFG_RSV6_OFS 8'hA1
`define BRAD_CFG_RSV7_OFS 8'hA9
`define BRAD_CFG_RSV8_OFS 8'hAD
`define BRAD_CFG_RSV9_LO 8'hAF

// Relocation register fields
`define BRAD_RELOC_X_MSB 5
`define BRAD_RELOC_X_LSB 2
`define BRAD_RELOC_Y_MSB 1
`define BRAD_RELOC_Y_LSB 0

// Window pair in memory space
`define BRAD_WIN_TOP 16'hFEC0
`define BRAD_SEL_LOW 8'h00
`define BRAD_WIN_LOW 8'h10

// Indirect indices
`define BRAD_IDX_ID 8'h00
`define BRAD_IDX_VER 8'h01
`define BRAD_IDX_ARB 8'h02
`define BRAD_IDX_RED_FIRST 8'h10
`define BRAD_IDX_RED_LAST 8'h2F
`define BRAD_ENTRY_WORDS 32

// BIOS timer base register
`define BRAD_BTMR_EN_BIT 0

// I/O locations also broadcast to ISA
`define BRAD_FWD_A 16'h0070
`define BRAD_FWD_B 16'h0060
`define BRAD_FWD_C 16'h0092
`define BRAD_FWD_D 16'h03F2
`define BRAD_FWD_E 16'h0372
`define BRAD_FWD_F 16'h00F0

// Default values
`define BRAD_RELOC_RST 8'h00
`define BRAD_BTMR_RST 16'h0000
`define BRAD_SEL_RST 8'h00
`define BRAD_ID_RST 32'h0000_0000
`define BRAD_ENTRY_RST 32'h0000_0000

`endif

// ### rtl/brad_pkg.sv
package brad_pkg;

  // Cycle type of an incoming access
  typedef enum logic [1:0] {
    BRAD_SP_CFG,
    BRAD_SP_IO,
    BRAD_SP_MEM,
    BRAD_SP_ISA_IO
  } brad_space_type;

  // Decoded target
  typedef enum logic [2:0] {
    BRAD_K_NONE,
    BRAD_K_CFG,
    BRAD_K_LEGACY,
    BRAD_K_SEL,
    BRAD_K_WIN
  } brad_kind_type;

  typedef enum logic {
    BRAD_IDLE,
    BRAD_ANSWER
  } brad_state_type;

  typedef struct packed {
    logic valid;
    brad_space_type space;
    logic write;
    logic [31:0] addr;
    logic [3:0] be_n;
    logic [31:0] wdata;
  } brad_req_type;

  typedef struct packed {
    logic done;
    logic hit;
    logic retry;
    logic target_abort;
    logic forward_isa;
    logic [31:0] rdata;
  } brad_resp_type;

endpackage

// ### rtl/brad_entry_mem.sv
`timescale 1ns/1ps
`default_nettype none

module brad_entry_mem #(
  parameter int AW = 5,
  parameter int DW = 32
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  // Read port
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Storage array, no reset
  always_ff @(posedge mclk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Registered read data
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

`default_nettype wire

// ### verification/brad_register_access_sva.sv
`timescale 1ns/1ps
`default_nettype none
module brad_register_access_sva
  import brad_pkg::*;
#(
  parameter int TREE_W = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Pins
  input wire logic hard_reset_in_n_i,
  input wire logic test_i,
  input wire logic [TREE_W-1:0] nand_tree_pins_i,
  input wire logic speaker_tone_i,
  input wire logic outputs_enable_o,
  input wire logic tone_or_tree_result_out_o,
  // Access side
  input wire brad_req_type req_i,
  input wire logic req_ready_o,
  input wire logic isa_owned_i,
  input wire brad_resp_type resp_o,
  input wire brad_req_type ext_req_o,
  input wire logic [31:0] ext_rdata_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic take;
  logic io_take;
  logic multi_io;
  // Qualified takes
  assign take = req_i.valid && req_ready_o;
  assign io_take = take && req_i.space == BRAD_SP_IO && !isa_owned_i;
  assign multi_io = io_take && $countones(~req_i.be_n) > 1;

  AST_ANSWER: assert property (take |=> !req_ready_o ##1 resp_o.done)
    else $error("answer missing two cycles after take");
  AST_SPUR: assert property (resp_o.done |-> $past(take, 2))
    else $error("answer without a request");
  AST_RETRY: assert property (take && isa_owned_i && req_i.space == BRAD_SP_CFG |-> ##2 resp_o.retry)
    else $error("no retry while isa bus owned");
  AST_RETRY_QUIET: assert property (resp_o.retry |-> resp_o.rdata == 32'h0 && !resp_o.forward_isa)
    else $error("retried access returned data or forwarded");
  AST_ABORT: assert property (resp_o.target_abort |-> $past(multi_io, 2))
    else $error("target abort without multi lane io");
  AST_FWD: assert property (resp_o.forward_isa |-> $past(io_take, 2))
    else $error("forward on a non io access");
  AST_MISS: assert property (take && req_i.space == BRAD_SP_MEM && req_i.addr[31:16] != 16'hFEC0
    |-> ##2 resp_o.done && !resp_o.hit)
    else $error("memory access outside window claimed");
  AST_TEST_OFF: assert property (test_i [*4] |=> !outputs_enable_o)
    else $error("outputs enabled in test mode");
  AST_TEST_ON: assert property (!test_i [*4] |=> outputs_enable_o)
    else $error("outputs disabled outside test mode");
  AST_TONE: assert property (!test_i [*4] |=> tone_or_tree_result_out_o == $past(speaker_tone_i))
    else $error("tone pin does not follow speaker");
  AST_HRST: assert property (!hard_reset_in_n_i [*3] |=> !req_ready_o)
    else $error("ready during hard reset");
endmodule

bind brad_register_access brad_register_access_sva #(.TREE_W(TREE_W)) u_sva (
  .mclk_i(mclk_i), .reset_i(reset_i), .hard_reset_in_n_i(hard_reset_in_n_i), .test_i(test_i),
  .nand_tree_pins_i(nand_tree_pins_i), .speaker_tone_i(speaker_tone_i), .outputs_enable_o(outputs_enable_o),
  .tone_or_tree_result_out_o(tone_or_tree_result_out_o), .req_i(req_i), .req_ready_o(req_ready_o),
  .isa_owned_i(isa_owned_i), .resp_o(resp_o), .ext_req_o(ext_req_o), .ext_rdata_i(ext_rdata_i)
);
`default_nettype wire

// ### verification/brad_slice_model.sv
`timescale 1ns/1ps
`default_nettype none
module brad_slice_model
  import brad_pkg::*;
(
  // Clock and request
  input wire logic mclk_i,
  input wire brad_req_type ext_req_i,
  // Read data
  output logic [31:0] ext_rdata_o
);
  logic [31:0] last;
  // Remember last value so idle data keeps changing
  always_ff @(posedge mclk_i) begin
    last <= ext_rdata_o;
  end
  // Address pattern while asked, inverse of last value otherwise
  assign ext_rdata_o = ext_req_i.valid ? {~ext_req_i.addr[15:0], ext_req_i.addr[15:0]} : ~last;
endmodule
`default_nettype wire

// ### verification/bridge_register_access_decode_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bridge_register_access_decode_bench
  import brad_pkg::*;
;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hard_reset_in_n_i = 1'b1;
  logic test_i = 1'b0;
  logic [7:0] nand_tree_pins_i = 8'h00;
  logic speaker_tone_i = 1'b0;
  logic isa_owned_i = 1'b0;
  brad_req_type req_i = '0;
  logic outputs_enable_o, tone_or_tree_result_out_o, req_ready_o;
  brad_resp_type resp_o, r;
  brad_req_type ext_req_o;
  logic [31:0] ext_rdata_i, base, d, ent [32];
  logic [3:0] x;
  logic [7:0] lo, hi, pins;
  logic [15:0] fwd [6] = '{16'h0070, 16'h0060, 16'h0092, 16'h03F2, 16'h0372, 16'h00F0};
  logic [7:0] rsv [4] = '{8'h0C, 8'h50, 8'h58, 8'h64};
  logic [7:0] ro [4] = '{8'h01, 8'h02, 8'h05, 8'h30};
  logic [3:0] bes [3] = '{4'hE, 4'hC, 4'h0};
  int n_mismatch = 0;
  int tests_run = 0;

  brad_register_access dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .hard_reset_in_n_i(hard_reset_in_n_i), .test_i(test_i),
    .nand_tree_pins_i(nand_tree_pins_i), .speaker_tone_i(speaker_tone_i), .outputs_enable_o(outputs_enable_o),
    .tone_or_tree_result_out_o(tone_or_tree_result_out_o), .req_i(req_i), .req_ready_o(req_ready_o),
    .isa_owned_i(isa_owned_i), .resp_o(resp_o), .ext_req_o(ext_req_o), .ext_rdata_i(ext_rdata_i)
  );
  brad_slice_model u_slice (.mclk_i(mclk_i), .ext_req_i(ext_req_o), .ext_rdata_o(ext_rdata_i));

  // Clock
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end

  // Expected chain result
  function automatic logic tree(input logic [7:0] p);
    logic c;
    c = p[0];
    for (int i = 1; i < 8; i++) c = ~(c & p[i]);
    return c;
  endfunction

  function automatic logic [31:0] base_of(input logic [3:0] bx, input logic [1:0] by);
    return {16'hFEC0, bx, by, 2'b00, 8'h00};
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  // One access: hold until taken, answer two edges later
  task automatic acc(input brad_space_type sp, input logic wr, input logic [31:0] a,
                     input logic [3:0] ben, input logic [31:0] wd);
    repeat (200) if (req_ready_o !== 1'b1) begin
      @(posedge mclk_i);
      #1;
    end
    req_i = '{1'b1, sp, wr, a, ben, wd};
    @(posedge mclk_i);
    #1 req_i.valid = 1'b0;
    @(posedge mclk_i);
    #1 r = resp_o;
  endtask

  task automatic cfg_wb(input logic [7:0] off, input logic [7:0] b);
    acc(BRAD_SP_CFG, 1'b1, {24'h0, off[7:2], 2'b00}, ~(4'h1 << off[1:0]), {4{b}});
  endtask

  task automatic io_rd(input logic [15:0] a);
    acc(BRAD_SP_IO, 1'b0, {16'h0, a[15:2], 2'b00}, ~(4'h1 << a[1:0]), 32'h0);
  endtask

  task automatic win_wr(input logic [7:0] idx, input logic [31:0] wd);
    acc(BRAD_SP_MEM, 1'b1, base, 4'hE, {24'h0, idx});
    acc(BRAD_SP_MEM, 1'b1, base + 32'h10, 4'h0, wd);
  endtask

  task automatic win_rd(input logic [7:0] idx);
    acc(BRAD_SP_MEM, 1'b1, base, 4'hE, {24'h0, idx});
    acc(BRAD_SP_MEM, 1'b0, base + 32'h10, 4'h0, 32'h0);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #(40 * 8000);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(16));
    base = 32'hFEC0_0000;
    repeat (10) @(posedge mclk_i);
    #1 reset_i = 1'b0;
    acc(BRAD_SP_MEM, 1'b0, base, 4'h0, 32'h0);
    chk_word(r.rdata, 32'h0);
    win_rd(8'h10);
    chk_word(r.rdata, 32'h0);
    $display("test defaults done");
    // Relocate through every y value
    for (int y = 0; y < 4; y++) begin
      x = $urandom_range(15);
      d = base;
      cfg_wb(8'h71, {2'b00, x, y[1:0]});
      base = base_of(x, y[1:0]);
      d = $urandom();
      win_wr(8'h00, d);
      win_rd(8'h00);
      chk_flag(r.hit, 1'b1);
      chk_word(r.rdata, d);
    end
    acc(BRAD_SP_MEM, 1'b0, base ^ 32'h0001_0000, 4'h0, 32'h0);
    chk_flag(r.hit, 1'b0);
    $display("test relocation done");
    for (int i = 0; i < 32; i++) begin
      ent[i] = $urandom();
      win_wr(8'h10 + i[7:0], ent[i]);
    end
    for (int i = 31; i >= 0; i--) begin
      win_rd(8'h10 + i[7:0]);
      chk_word(r.rdata, ent[i]);
    end
    foreach (ro[i]) begin
      win_wr(ro[i], 32'hFFFF_FFFF);
      win_rd(ro[i]);
      chk_word(r.rdata, 32'h0);
    end
    $display("test indirect map done");
    foreach (rsv[i]) begin
      acc(BRAD_SP_CFG, 1'b1, {24'h0, rsv[i]}, 4'h0, 32'hFFFF_FFFF);
      chk_flag(r.done, 1'b1);
      acc(BRAD_SP_CFG, 1'b0, {24'h0, rsv[i]}, 4'h0, 32'h0);
      chk_word(r.rdata, 32'h0);
    end
    lo = 8'($urandom()) & 8'hFC;
    hi = 8'($urandom());
    cfg_wb(8'h80, lo);
    cfg_wb(8'h81, hi);
    acc(BRAD_SP_CFG, 1'b0, 32'h80, 4'h0, 32'h0);
    chk_word(r.rdata, {16'h0, hi, lo});
    $display("test config done");
    foreach (fwd[i]) begin
      io_rd(fwd[i]);
      chk_flag(r.forward_isa, 1'b1);
    end
    io_rd(16'h0021);
    chk_flag(r.forward_isa, 1'b0);
    acc(BRAD_SP_IO, 1'b1, 32'h20, 4'hC, 32'h0);
    chk_flag(r.target_abort, 1'b1);
    for (int en = 0; en < 2; en++) begin
      acc(BRAD_SP_CFG, 1'b1, 32'h80, 4'hC, {16'h0, 15'h0240, en[0]});
      foreach (bes[i]) begin
        acc(BRAD_SP_IO, 1'b0, 32'h480, bes[i], 32'h0);
        chk_flag(r.target_abort, 1'b0);
        chk_flag(r.forward_isa, en == 0);
        if (en == 1) chk_word(r.rdata, {~16'h0480, 16'h0480});
      end
    end
    isa_owned_i = 1'b1;
    acc(BRAD_SP_CFG, 1'b1, 32'h80, 4'hC, 32'h0);
    chk_flag(r.retry, 1'b1);
    io_rd(16'h0070);
    chk_flag(r.retry, 1'b1);
    isa_owned_i = 1'b0;
    acc(BRAD_SP_CFG, 1'b0, 32'h80, 4'h0, 32'h0);
    chk_word(r.rdata, 32'h0000_0481);
    $display("test legacy done");
    for (int k = 0; k < 4; k++) begin
      pins = (k == 0) ? 8'hFF : 8'($urandom());
      nand_tree_pins_i = pins;
      test_i = 1'b1;
      repeat (6) @(posedge mclk_i);
      #1;
      chk_flag(outputs_enable_o, 1'b0);
      chk_flag(tone_or_tree_result_out_o, tree(pins));
    end
    test_i = 1'b0;
    repeat (5) @(posedge mclk_i);
    for (int k = 0; k < 8; k++) begin
      #1 speaker_tone_i = 1'($urandom());
      @(posedge mclk_i);
      #1;
      chk_flag(tone_or_tree_result_out_o, speaker_tone_i);
      chk_flag(outputs_enable_o, 1'b1);
    end
    $display("test pins done");
    hard_reset_in_n_i = 1'b0;
    repeat (5) @(posedge mclk_i);
    #1 hard_reset_in_n_i = 1'b1;
    base = 32'hFEC0_0000;
    win_rd(8'h11);
    chk_word(r.rdata, 32'h0);
    acc(BRAD_SP_CFG, 1'b0, 32'h80, 4'h0, 32'h0);
    chk_word(r.rdata, 32'h0);
    $display("test hard reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
